// *** sbsc_pkg.sv ***
// Constants for the stepper bridge serial control block.
// Assumes a 20 MHz system clock; no other package is needed.
package sbsc_pkg;

  // ==========================================================================
  // Command byte layout
  localparam int BYTE_W = 8;
  localparam int BIT_FLAG_HI = 7;
  localparam int BIT_FLAG_LO = 6;
  localparam int BIT_A_RANGE_HI = 5;
  localparam int BIT_A_RANGE_LO = 4;
  localparam int BIT_A_POL = 3;
  localparam int BIT_B_RANGE_HI = 2;
  localparam int BIT_B_RANGE_LO = 1;
  localparam int BIT_B_POL = 0;
  localparam logic [7:0] CMD_RESET = 8'h3F;

  // Current range codes (range bits high, low)
  localparam logic [1:0] RANGE_OFF = 2'h3;
  localparam logic [1:0] RANGE_HOLD = 2'h2;

  // ==========================================================================
  // Diagnosis
  localparam int FILTER_SETTLE = 4;
  localparam int SHORT_RETRIES = 8;
  localparam logic [1:0] ERR_NONE = 2'h3;
  localparam logic [1:0] ERR_SUPPLY = 2'h1;
  localparam logic [1:0] ERR_GROUND = 2'h2;
  localparam logic [1:0] ERR_TEMP = 2'h0;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int REVERSE_GAP_NS = 1000;
  localparam int REVERSE_GAP_CYC = (REVERSE_GAP_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int ENABLE_SETUP_US = 30;
  localparam int ENABLE_SETUP_CYC = ENABLE_SETUP_US * (CLK_HZ / 1000000);

endpackage : sbsc_pkg

// *** sbsc_buf2.sv ***
// Two-entry valid/ready buffer for received command bytes.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module sbsc_buf2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } sbsc_buf_state_t;

  sbsc_buf_state_t st_reg;
  sbsc_buf_state_t st_next;
  logic push;
  logic pop;

  assign in_ready_o = (st_reg.cnt != 2'h2);
  assign out_valid_o = (st_reg.cnt != 2'h0);
  assign out_data_o = st_reg.mem[st_reg.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data_i;
      st_next.wr = ~st_reg.wr;
    end
    if (pop) begin
      st_next.rd = ~st_reg.rd;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : sbsc_buf2

// *** sbsc_core.sv ***
// Serial command link and diagnosis flag logic of a two-bridge stepper driver.
// Assumes link pins and fault events arrive asynchronously; all are synchronised.
`timescale 1ns/1ps
module sbsc_core #(
  parameter int SETTLE_PULSES = sbsc_pkg::FILTER_SETTLE,
  parameter int RETRY_LIMIT = sbsc_pkg::SHORT_RETRIES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Device enable, low active
  input wire logic device_enable_level_n_i,
  // Serial link
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Chopper and fault events, per bridge (index 0 = A, 1 = B); over temperature is shared
  input wire logic [1:0] chop_pulse_i,
  input wire logic [1:0] sink_short_i,
  input wire logic [1:0] source_overload_i,
  input wire logic [1:0] flyback_seen_i,
  input wire logic over_temp_i,
  // Bridge drive
  output logic [1:0] bridge_on_o,
  output logic [1:0] bridge_pol_o,
  output logic [3:0] bridge_range_o,
  output logic [1:0] sink_inhibit_o,
  output logic device_ready_o
);

  // ==========================================================================
  // Input synchronisers
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] raw;
  assign raw = {over_temp_i, flyback_seen_i, source_overload_i, sink_short_i,
                chop_pulse_i, sdi_i, sclk_i, chip_select_n_i, device_enable_level_n_i};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_reg <= {NSYNC{1'b1}};
      s2_reg <= {NSYNC{1'b1}};
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end

  logic en_n;
  logic chip_select_n;
  logic sck;
  logic sdi;
  logic [1:0] chop;
  logic [1:0] sshort;
  logic [1:0] sover;
  logic [1:0] fly;
  logic otemp;
  assign en_n = s2_reg[0];
  assign chip_select_n = s2_reg[1];
  assign sck = s2_reg[2];
  assign sdi = s2_reg[3];
  assign chop = s2_reg[5:4];
  assign sshort = s2_reg[7:6];
  assign sover = s2_reg[9:8];
  assign fly = s2_reg[11:10];
  assign otemp = s2_reg[12];

  // ==========================================================================
  // State
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAKE = 2'b01,
    ST_RUN = 2'b10
  } sbsc_mode_t;

  typedef struct packed {
    sbsc_mode_t mode;
    logic [15:0] wake_cnt;
    logic csn_d;
    logic sck_d;
    logic [1:0] chop_d;
    logic [7:0] shreg;
    logic [2:0] fall_cnt;
    logic got_edge;
    logic [7:0] cmd;
    logic [1:0] pend_pol;
    logic [1:0] rev_busy;
    logic [1:0][7:0] rev_cnt;
    logic [1:0][2:0] settle;
    logic [1:0][3:0] retry;
    logic [1:0] sink_off;
    logic supply_flag;
    logic open_flag;
    logic gnd_flag;
    logic sdo;
    logic sdo_oe;
    logic [1:0] on;
    logic [1:0] pol;
  } sbsc_state_t;

  sbsc_state_t st_reg;
  sbsc_state_t st_next;

  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] buf_out_data;

  function automatic logic [1:0] range_of(input logic [7:0] c, input int b);
    range_of = (b == 0) ? c[sbsc_pkg::BIT_A_RANGE_HI:sbsc_pkg::BIT_A_RANGE_LO]
                        : c[sbsc_pkg::BIT_B_RANGE_HI:sbsc_pkg::BIT_B_RANGE_LO];
  endfunction : range_of

  function automatic logic pol_of(input logic [7:0] c, input int b);
    pol_of = (b == 0) ? c[sbsc_pkg::BIT_A_POL] : c[sbsc_pkg::BIT_B_POL];
  endfunction : pol_of

  logic sck_rise;
  logic sck_fall;
  logic frame_end;
  assign sck_rise = sck && !st_reg.sck_d && !chip_select_n;
  assign sck_fall = !sck && st_reg.sck_d && !chip_select_n;
  assign frame_end = chip_select_n && !st_reg.csn_d;
  // Only whole bytes queue a command
  assign buf_in_valid = frame_end && st_reg.got_edge && (st_reg.fall_cnt == 3'h0)
                        && (st_reg.mode == ST_RUN);

  sbsc_buf2 #(
    .WIDTH(sbsc_pkg::BYTE_W)
  ) u_cmd_buf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(st_reg.shreg),
    .out_valid_o(buf_out_valid),
    .out_ready_i(st_reg.rev_busy == 2'h0),
    .out_data_o(buf_out_data)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic [1:0] rng;
    logic chopping;
    logic chop_any;
    logic sup_any;
    rng = 2'h0;
    chopping = 1'b0;
    chop_any = 1'b0;
    sup_any = 1'b0;
    st_next = st_reg;
    st_next.csn_d = chip_select_n;
    st_next.sck_d = sck;
    st_next.chop_d = chop;
    case (st_reg.mode)
      ST_OFF: begin
        if (!en_n) begin
          st_next.mode = ST_WAKE;
          st_next.wake_cnt = '0;
        end
      end
      ST_WAKE: begin
        st_next.wake_cnt = st_reg.wake_cnt + 16'h0001;
        if (st_reg.wake_cnt == 16'(sbsc_pkg::ENABLE_SETUP_CYC - 1)) begin
          st_next.mode = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      default: st_next.mode = ST_OFF;
    endcase

    // Serial shifting, MSB first
    if (!chip_select_n && st_reg.csn_d) begin
      st_next.fall_cnt = 3'h0;
      st_next.got_edge = 1'b0;
      st_next.shreg = {st_reg.supply_flag || st_reg.open_flag || otemp ? 1'b0 : 1'b1,
                       st_reg.gnd_flag || otemp ? 1'b0 : 1'b1,
                       st_reg.cmd[5:0]};
      st_next.sdo = st_next.shreg[7];
    end
    if (sck_rise) begin
      st_next.shreg = {st_reg.shreg[6:0], sdi};
    end
    if (sck_fall) begin
      st_next.sdo = st_reg.shreg[7];
      st_next.fall_cnt = st_reg.fall_cnt + 3'h1;
      st_next.got_edge = 1'b1;
    end
    st_next.sdo_oe = !chip_select_n;

    // New byte clears overload and retry lockout
    if (buf_in_valid && buf_in_ready) begin
      st_next.gnd_flag = 1'b0;
      st_next.sink_off = 2'h0;
      st_next.retry = '0;
    end

    // Apply buffered command, turning a reversing bridge off first
    if (buf_out_valid && st_reg.rev_busy == 2'h0) begin
      st_next.cmd = buf_out_data;
      for (int b = 0; b < 2; b++) begin
        rng = range_of(buf_out_data, b);
        st_next.pend_pol[b] = pol_of(buf_out_data, b);
        if (rng == sbsc_pkg::RANGE_OFF) begin
          st_next.on[b] = 1'b0;
          st_next.pol[b] = pol_of(buf_out_data, b);
        end else if (st_reg.on[b] && pol_of(buf_out_data, b) != st_reg.pol[b]) begin
          st_next.on[b] = 1'b0;
          st_next.rev_busy[b] = 1'b1;
          st_next.rev_cnt[b] = '0;
          // Flyback check at polarity change, blanked at hold or filter unsettled
          if (!fly[b] && rng != sbsc_pkg::RANGE_HOLD && range_of(st_reg.cmd, b) !=
              sbsc_pkg::RANGE_HOLD) begin
            if (st_reg.settle[b] == 3'(SETTLE_PULSES)) begin
              st_next.open_flag = 1'b1;
            end
          end
          if (st_reg.settle[b] != 3'(SETTLE_PULSES)) begin
            st_next.settle[b] = st_reg.settle[b] + 3'h1;
          end
        end else begin
          st_next.on[b] = 1'b1;
          st_next.pol[b] = pol_of(buf_out_data, b);
        end
      end
    end

    for (int b = 0; b < 2; b++) begin
      rng = range_of(st_reg.cmd, b);
      if (st_reg.rev_busy[b]) begin
        st_next.rev_cnt[b] = st_reg.rev_cnt[b] + 8'h01;
        if (st_reg.rev_cnt[b] == 8'(sbsc_pkg::REVERSE_GAP_CYC - 1)) begin
          st_next.rev_busy[b] = 1'b0;
          st_next.on[b] = 1'b1;
          st_next.pol[b] = st_reg.pend_pol[b];
        end
      end
      chopping = chop[b] && !st_reg.chop_d[b] && st_reg.on[b];
      if (chopping) begin
        if (st_reg.settle[b] != 3'(SETTLE_PULSES)) begin
          st_next.settle[b] = st_reg.settle[b] + 3'h1;
        end
        // Comparator response rewrites the supply flag
        chop_any = 1'b1;
        if (sshort[b] && st_reg.settle[b] == 3'(SETTLE_PULSES)) begin
          sup_any = 1'b1;
        end
        if (!sshort[b]) begin
          st_next.open_flag = 1'b0;
        end
        if (sshort[b]) begin
          if (st_reg.retry[b] == 4'(RETRY_LIMIT - 1)) begin
            st_next.sink_off[b] = 1'b1;
          end else begin
            st_next.retry[b] = st_reg.retry[b] + 4'h1;
          end
        end else begin
          st_next.retry[b] = 4'h0;
        end
        // PWM flyback at hold still checked
        if (!fly[b] && rng == sbsc_pkg::RANGE_HOLD && !sshort[b]
            && st_reg.settle[b] == 3'(SETTLE_PULSES)) begin
          st_next.open_flag = 1'b1;
        end
      end
      if (sover[b] && st_reg.on[b]) begin
        st_next.gnd_flag = 1'b1;
        st_next.on[b] = 1'b0;
      end
    end

    // Both bridges share one flag: any responding short keeps it set
    if (chop_any) begin
      st_next.supply_flag = sup_any;
    end

    // Enable inactive resets all state; link edge trackers and sdo enable follow the pins
    if (en_n) begin
      st_next = '0;
      st_next.mode = ST_OFF;
      st_next.cmd = sbsc_pkg::CMD_RESET;
      st_next.csn_d = chip_select_n;
      st_next.sck_d = sck;
      st_next.sdo_oe = !chip_select_n;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
      st_reg.cmd <= sbsc_pkg::CMD_RESET;
      st_reg.csn_d <= 1'b1;
      st_reg.sck_d <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  logic [3:0] range_q;
  logic ready_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      range_q <= 4'hF;
      ready_q <= 1'b0;
    end else begin
      range_q <= {st_next.cmd[5:4], st_next.cmd[2:1]};
      ready_q <= (st_reg.mode == ST_RUN);
    end
  end

  assign sdo_o = st_reg.sdo;
  assign sdo_oe_o = st_reg.sdo_oe;
  assign bridge_on_o = st_reg.on;
  assign bridge_pol_o = st_reg.pol;
  assign bridge_range_o = range_q;
  assign sink_inhibit_o = st_reg.sink_off;
  assign device_ready_o = ready_q;

endmodule : sbsc_core

// *** sbsc_chk.sv ***
// Port-level assertions for the stepper bridge serial control core.
// Assumes binding into sbsc_core; sees only its ports.
`timescale 1ns/1ps
module sbsc_chk #(
  parameter int SETTLE_PULSES = 4,
  parameter int RETRY_LIMIT = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic device_enable_level_n_i,
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic [1:0] chop_pulse_i,
  input wire logic [1:0] sink_short_i,
  input wire logic [1:0] source_overload_i,
  input wire logic [1:0] flyback_seen_i,
  input wire logic over_temp_i,
  input wire logic [1:0] bridge_on_o,
  input wire logic [1:0] bridge_pol_o,
  input wire logic [3:0] bridge_range_o,
  input wire logic [1:0] sink_inhibit_o,
  input wire logic device_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================================
  // Helper counters
  logic [7:0] since_end;
  logic [7:0] hist;
  logic [10:0] en_low;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      since_end <= 8'hFF;
      hist <= 8'h00;
      en_low <= 11'h000;
    end else begin
      if ($rose(chip_select_n_i) || device_enable_level_n_i) since_end <= 8'h00;
      else if (since_end != 8'hFF) since_end <= since_end + 8'h01;
      hist <= {hist[6:0], $fell(sclk_i) || $fell(chip_select_n_i)};
      if (device_enable_level_n_i) en_low <= 11'h000;
      else if (en_low != 11'h7FF) en_low <= en_low + 11'h001;
    end
  end
  // ==========================================================================
  // Properties
  property p_off;
    (bridge_range_o[3:2] != sbsc_pkg::RANGE_OFF || !bridge_on_o[0]) &&
      (bridge_range_o[1:0] != sbsc_pkg::RANGE_OFF || !bridge_on_o[1]);
  endproperty
  a_off: assert property (p_off) else $error("bridge on at off range");
  property p_rev;
    ((bridge_on_o & $past(bridge_on_o)) & (bridge_pol_o ^ $past(bridge_pol_o))) == 2'h0;
  endproperty
  a_rev: assert property (p_rev) else $error("polarity flipped while on");
  property p_ready;
    $rose(device_ready_o) |-> en_low >= sbsc_pkg::ENABLE_SETUP_CYC;
  endproperty
  a_ready: assert property (p_ready) else $error("ready too early");
  property p_en_reset;
    device_enable_level_n_i [*6] |-> !device_ready_o && bridge_range_o == 4'hF &&
      bridge_on_o == 2'h0;
  endproperty
  a_en_reset: assert property (p_en_reset) else $error("enable high not resetting");
  property p_oe_on;
    $fell(chip_select_n_i) |-> ##[1:5] sdo_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo not driven in frame");
  property p_oe_off;
    chip_select_n_i [*5] |-> !sdo_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
  property p_sdo;
    sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> hist != 8'h00;
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved without clock fall");
  property p_range;
    $changed(bridge_range_o) |-> since_end <= 8'h28;
  endproperty
  a_range: assert property (p_range) else $error("range moved outside frame end");
  property p_inhibit;
    $fell(sink_inhibit_o[0]) |-> since_end <= 8'h28;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("sink lock freed early");
endmodule : sbsc_chk

bind sbsc_core sbsc_chk #(.SETTLE_PULSES(SETTLE_PULSES), .RETRY_LIMIT(RETRY_LIMIT)) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .device_enable_level_n_i(device_enable_level_n_i),
  .chip_select_n_i(chip_select_n_i), .sclk_i(sclk_i), .sdi_i(sdi_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .chop_pulse_i(chop_pulse_i), .sink_short_i(sink_short_i),
  .source_overload_i(source_overload_i), .flyback_seen_i(flyback_seen_i),
  .over_temp_i(over_temp_i), .bridge_on_o(bridge_on_o), .bridge_pol_o(bridge_pol_o),
  .bridge_range_o(bridge_range_o), .sink_inhibit_o(sink_inhibit_o),
  .device_ready_o(device_ready_o));

// *** sbsc_master.sv ***
// Serial link controller model driving frames into the core.
// Assumes a 50 ns clock; serial clock of 400 ns, idle low outside frames.
`timescale 1ns/1ps
module sbsc_master (
  // Clock
  input wire logic clk_i,
  // Serial link
  input wire logic sdo_i,
  output logic chip_select_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial begin
    chip_select_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic gap;
    repeat (4) @(negedge clk_i);
  endtask : gap
  // Bits leave from data[15] down; rx collects sdo at each rising clock
  task automatic xfer(input logic [15:0] data, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n_o = 1'b0;
    gap();
    for (int i = 0; i < nbits; i++) begin
      sdi_o = data[15 - i];
      gap();
      rx = {rx[14:0], sdo_i};
      sclk_o = 1'b1;
      gap();
      sclk_o = 1'b0;
    end
    gap();
    chip_select_n_o = 1'b1;
    sdi_o = ~sdi_o;
    gap();
    gap();
  endtask : xfer
endmodule : sbsc_master

// *** stepper_bridge_serial_control_test.sv ***
// Self-checking bench for the stepper bridge serial control core.
// Assumes sbsc_core, sbsc_master and the bound checker are compiled first.
`timescale 1ns/1ps
module stepper_bridge_serial_control_test;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic dev_en_n = 1'b1;
  logic cs_n, sclk, sdi, sdo, sdo_oe, sdo_w, ready, over_temp = 1'b0;
  logic [1:0] chop = 2'h0, sink_short = 2'h0, overload = 2'h0, b_on, b_pol, inhibit;
  logic [3:0] b_range;
  logic [1:0] fly = 2'h3;
  logic [15:0] rx;
  logic [7:0] b0, b1;
  logic [5:0] last = 6'h3F;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int en_at = 0;
  int bad[3] = '{0, 7, 9};
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) cyc++;
  // Released line shows a changing pattern
  assign sdo_w = sdo_oe ? sdo : clk_i;
  sbsc_core uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .device_enable_level_n_i(dev_en_n),
    .chip_select_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .chop_pulse_i(chop), .sink_short_i(sink_short), .source_overload_i(overload),
    .flyback_seen_i(fly), .over_temp_i(over_temp), .bridge_on_o(b_on),
    .bridge_pol_o(b_pol), .bridge_range_o(b_range), .sink_inhibit_o(inhibit),
    .device_ready_o(ready));
  sbsc_master m (.clk_i(clk_i), .sdo_i(sdo_w), .chip_select_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi));
  // ==========================================================================
  // Compare tasks and model
  task automatic chk_rx(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: status %h expected %h", $time, got, exp);
    end
  endtask : chk_rx
  task automatic chk_drv(input logic [7:0] exp);
    n_checks++;
    if ({b_on, b_pol, b_range} !== exp) begin
      n_errors++;
      $display("mismatch at %0t: drive %h expected %h", $time, {b_on, b_pol, b_range}, exp);
    end
  endtask : chk_drv
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  function automatic logic [7:0] drv_exp(input logic [7:0] c);
    return {c[2:1] != 2'h3, c[5:4] != 2'h3, c[0], c[3], c[5:4], c[2:1]};
  endfunction : drv_exp
  task automatic frame(input logic [7:0] cmd, input logic [1:0] flg);
    m.xfer({cmd, 8'h00}, 8, rx);
    chk_rx(rx[7:0], {flg, last});
    last = cmd[5:0];
    repeat (50) @(negedge clk_i);
    chk_drv(drv_exp({2'h0, last}));
  endtask : frame
  task automatic chop_n(input int n);
    repeat (n) begin
      chop = 2'h3;
      repeat (4) @(negedge clk_i);
      chop = 2'h0;
      repeat (4) @(negedge clk_i);
    end
  endtask : chop_n
  task automatic wait_ready;
    for (int k = 0; k < 700 && ready !== 1'b1; k++) @(negedge clk_i);
    chk_bit(ready, 1'b1);
    chk_bit((cyc - en_at) >= sbsc_pkg::ENABLE_SETUP_CYC, 1'b1);
  endtask : wait_ready
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
  // ==========================================================================
  // Tests
  initial begin
    b0 = 8'($urandom(32'hBECAF4E0));
    repeat (6) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk_drv(8'h0F);
    chk_bit(ready, 1'b0);
    dev_en_n = 1'b0;
    en_at = cyc;
    m.xfer(16'h0000, 8, rx);
    chk_drv(8'h0F);
    wait_ready();
    chop_n(4);
    $display("test startup done");
    for (int i = 0; i < 6; i++) frame(8'($urandom) & 8'h3F, sbsc_pkg::ERR_NONE);
    frame(8'h00, sbsc_pkg::ERR_NONE);
    m.xfer(16'h0800, 8, rx);
    repeat (8) @(negedge clk_i);
    chk_bit(b_on[0], 1'b0);
    repeat (40) @(negedge clk_i);
    chk_drv(drv_exp(8'h08));
    last = 6'h08;
    $display("test commands done");
    foreach (bad[i]) begin
      m.xfer(16'h3F3F, bad[i], rx);
      repeat (40) @(negedge clk_i);
      chk_drv(drv_exp({2'h0, last}));
    end
    frame(8'h00, sbsc_pkg::ERR_NONE);
    b0 = 8'($urandom) & 8'h3F;
    b1 = 8'($urandom) & 8'h3F;
    m.xfer({b0, b1}, 16, rx);
    chk_rx(rx[15:8], {sbsc_pkg::ERR_NONE, last});
    chk_rx(rx[7:0], b0);
    repeat (50) @(negedge clk_i);
    chk_drv(drv_exp(b1));
    last = b1[5:0];
    $display("test framing done");
    frame(8'h00, sbsc_pkg::ERR_NONE);
    sink_short = 2'h1;
    chop_n(8);
    chk_bit(inhibit[0], 1'b1);
    sink_short = 2'h0;
    frame(8'h00, sbsc_pkg::ERR_SUPPLY);
    chk_bit(inhibit[0], 1'b0);
    frame(8'h00, sbsc_pkg::ERR_SUPPLY);
    repeat (20000) @(negedge clk_i);
    frame(8'h24, sbsc_pkg::ERR_SUPPLY);
    chop_n(4);
    frame(8'h00, sbsc_pkg::ERR_NONE);
    sink_short = 2'h1;
    chop_n(8);
    sink_short = 2'h0;
    dev_en_n = 1'b1;
    repeat (10) @(negedge clk_i);
    chk_drv(8'h0F);
    chk_bit(ready, 1'b0);
    dev_en_n = 1'b0;
    en_at = cyc;
    wait_ready();
    last = 6'h3F;
    frame(8'h00, sbsc_pkg::ERR_NONE);
    $display("test supply short done");
    over_temp = 1'b1;
    chop_n(4);
    frame(8'h00, sbsc_pkg::ERR_TEMP);
    over_temp = 1'b0;
    chop_n(4);
    frame(8'h00, sbsc_pkg::ERR_NONE);
    overload = 2'h2;
    chop_n(4);
    chk_bit(b_on[1], 1'b0);
    overload = 2'h0;
    frame(8'h00, sbsc_pkg::ERR_GROUND);
    frame(8'h00, sbsc_pkg::ERR_NONE);
    fly = 2'h0;
    frame(8'h24, sbsc_pkg::ERR_NONE);
    frame(8'h2D, sbsc_pkg::ERR_NONE);
    frame(8'h00, sbsc_pkg::ERR_NONE);
    frame(8'h09, sbsc_pkg::ERR_NONE);
    frame(8'h09, sbsc_pkg::ERR_SUPPLY);
    fly = 2'h3;
    chop_n(1);
    frame(8'h24, sbsc_pkg::ERR_NONE);
    fly = 2'h0;
    chop_n(1);
    frame(8'h24, sbsc_pkg::ERR_SUPPLY);
    fly = 2'h3;
    chop_n(1);
    frame(8'h00, sbsc_pkg::ERR_NONE);
    $display("test faults done");
    wrap_up();
  end
endmodule : stepper_bridge_serial_control_test
